// ==== hdl/uart_with_fifos.v ====
`timescale 1ns/10ps
`include "uart_regs.vh"
module uart_with_fifos #(
    parameter DEPTH = 32
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // Register port
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [31:0] rdata,
    // Serial pins
    input  wire        rxd,
    input  wire        cts_n,
    output reg         txd,
    output reg         rts_n,
    // Interrupt and power
    output reg         irq,
    output reg         peripheral_power_status
);
    ////////////////////////////////////////////////////////////////////////////
    // Registers
    reg [7:0]  ctrl_r;
    reg [15:0] baud_r;
    reg [4:0]  fmt_r;
    reg [3:0]  ien_r;
    reg [3:0]  ist_r;
    reg        peripheral_power_enable_r;
    reg        rx_s1_r, rx_s2_r, cts_s1_r, cts_s2_r;

    wire pwr = peripheral_power_enable_r;
    wire [3:0] nbits = {2'b00, fmt_r[1:0]} + 4'd5;

    function parity_of;
        input [7:0] d;
        input [3:0] n;
        input       odd;
        integer k;
        begin
            parity_of = odd;
            for (k = 0; k < 8; k = k + 1) begin
                if (k < n) begin
                    parity_of = parity_of ^ d[k];
                end
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // FIFOs
    wire       txf_empty, txf_full, rxf_empty, rxf_full;
    wire [7:0] txf_q;
    wire [11:0] rxf_q;
    wire [5:0] txf_cnt, rxf_cnt;
    wire       txf_wr = wr && pwr && addr == `UART_DATA_ADDR;
    wire       rxf_rd = rd && pwr && addr == `UART_DATA_ADDR;
    reg        tx_pop;
    reg        rx_push;
    reg [11:0] rx_entry;

    uart_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(5)) u_txf (
        .clk(clk), .rst(rst), .wr_en(txf_wr), .wr_data(wdata[7:0]),
        .rd_en(tx_pop), .rd_data(txf_q), .empty(txf_empty),
        .full(txf_full), .count(txf_cnt)
    );

    uart_fifo #(.WIDTH(12), .DEPTH(DEPTH), .AW(5)) u_rxf (
        .clk(clk), .rst(rst), .wr_en(rx_push), .wr_data(rx_entry),
        .rd_en(rxf_rd), .rd_data(rxf_q), .empty(rxf_empty),
        .full(rxf_full), .count(rxf_cnt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Baud tick at 16x bit rate
    reg [15:0] bdiv_r;
    reg        tick_r;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            bdiv_r <= 16'h0000;
            tick_r <= 1'b0;
        end else if (!pwr || bdiv_r >= baud_r) begin
            bdiv_r <= 16'h0000;
            tick_r <= pwr;
        end else begin
            bdiv_r <= bdiv_r + 16'h0001;
            tick_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter
    localparam TX_IDLE = 2'd0, TX_SHIFT = 2'd1, TX_STOP = 2'd2;
    reg [1:0]  tx_st_r;
    reg [10:0] tx_sh_r;
    reg [3:0]  tx_bits_r;
    reg [3:0]  tx_ovs_r;
    reg        tx_done;
    wire       rx_busy;
    wire tx_ok = ctrl_r[`CTRL_TXEN] && !txf_empty &&
                 !(ctrl_r[`CTRL_FLOW] && cts_s2_r) &&
                 !(ctrl_r[`CTRL_HALF] && rx_busy);
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_st_r   <= TX_IDLE;
            tx_sh_r   <= 11'h7FF;
            tx_bits_r <= 4'h0;
            tx_ovs_r  <= 4'h0;
            txd       <= 1'b1;
            tx_pop    <= 1'b0;
            tx_done   <= 1'b0;
        end else begin
            tx_pop  <= 1'b0;
            tx_done <= 1'b0;
            case (tx_st_r)
                TX_IDLE: begin
                    txd <= 1'b1;
                    if (tx_ok && !tx_pop && pwr) begin
                        tx_sh_r <= {1'b1, 1'b1,
                            parity_of(txf_q, nbits, fmt_r[`FMT_PAR_ODD]),
                            txf_q};
                        if (!fmt_r[`FMT_PAR_EN])
                            tx_sh_r[nbits] <= 1'b1;
                        else
                            tx_sh_r[nbits] <= parity_of(txf_q, nbits,
                                                        fmt_r[`FMT_PAR_ODD]);
                        tx_bits_r <= nbits + {3'b000, fmt_r[`FMT_PAR_EN]};
                        tx_pop    <= 1'b1;
                        tx_ovs_r  <= 4'h0;
                        txd       <= 1'b0;
                        tx_st_r   <= TX_SHIFT;
                    end
                end
                TX_SHIFT: if (tick_r) begin
                    tx_ovs_r <= tx_ovs_r + 4'h1;
                    if (tx_ovs_r == 4'hF) begin
                        if (tx_bits_r == 4'h0) begin
                            txd      <= 1'b1;
                            tx_bits_r <= fmt_r[`FMT_STOP2] ? 4'h1 : 4'h0;
                            tx_st_r  <= TX_STOP;
                        end else begin
                            txd       <= tx_sh_r[0];
                            tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
                            tx_bits_r <= tx_bits_r - 4'h1;
                        end
                    end
                end
                TX_STOP: if (tick_r) begin
                    tx_ovs_r <= tx_ovs_r + 4'h1;
                    if (tx_ovs_r == 4'hF) begin
                        if (tx_bits_r == 4'h0) begin
                            tx_st_r <= TX_IDLE;
                            tx_done <= 1'b1;
                        end else begin
                            tx_bits_r <= tx_bits_r - 4'h1;
                        end
                    end
                end
                default: tx_st_r <= TX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver
    localparam RX_IDLE = 2'd0, RX_START = 2'd1, RX_DATA = 2'd2, RX_STOP = 2'd3;
    reg [1:0] rx_st_r;
    reg [3:0] rx_ovs_r;
    reg [3:0] rx_cnt_r;
    reg [8:0] rx_sh_r;
    reg       rx_err;
    wire rx_in = ctrl_r[`CTRL_LOOP] ? txd : rx_s2_r;
    wire [3:0] rx_need = nbits + {3'b000, fmt_r[`FMT_PAR_EN]};
    assign rx_busy = (rx_st_r != RX_IDLE);
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_st_r  <= RX_IDLE;
            rx_ovs_r <= 4'h0;
            rx_cnt_r <= 4'h0;
            rx_sh_r  <= 9'h000;
            rx_push  <= 1'b0;
            rx_entry <= 12'h000;
            rx_err   <= 1'b0;
        end else begin
            rx_push <= 1'b0;
            rx_err  <= 1'b0;
            case (rx_st_r)
                RX_IDLE: if (tick_r && ctrl_r[`CTRL_RXEN] && !rx_in) begin
                    rx_ovs_r <= 4'h0;
                    rx_st_r  <= RX_START;
                end
                RX_START: if (tick_r) begin
                    rx_ovs_r <= rx_ovs_r + 4'h1;
                    if (rx_ovs_r == 4'h7) begin
                        rx_ovs_r <= 4'h0;
                        rx_cnt_r <= 4'h0;
                        rx_sh_r  <= 9'h000;
                        rx_st_r  <= rx_in ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: if (tick_r) begin
                    rx_ovs_r <= rx_ovs_r + 4'h1;
                    if (rx_ovs_r == 4'hF) begin
                        rx_sh_r[rx_cnt_r] <= rx_in;
                        rx_cnt_r <= rx_cnt_r + 4'h1;
                        if (rx_cnt_r + 4'h1 == rx_need)
                            rx_st_r <= RX_STOP;
                    end
                end
                RX_STOP: if (tick_r) begin
                    rx_ovs_r <= rx_ovs_r + 4'h1;
                    if (rx_ovs_r == 4'hF) begin
                        rx_entry[7:0] <= rx_sh_r[7:0] &
                                         ~(8'hFF << nbits);
                        rx_entry[`RXE_FRAME]   <= !rx_in;
                        rx_entry[`RXE_PARITY]  <= fmt_r[`FMT_PAR_EN] &&
                            (rx_sh_r[nbits] != parity_of(rx_sh_r[7:0], nbits,
                                                         fmt_r[`FMT_PAR_ODD]));
                        rx_entry[`RXE_BREAK]   <= !rx_in && rx_sh_r == 9'h000;
                        rx_entry[`RXE_OVERRUN] <= rxf_full;
                        rx_err  <= !rx_in || rxf_full;
                        rx_push <= 1'b1;
                        rx_st_r <= RX_IDLE;
                    end
                end
                default: rx_st_r <= RX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register access, sync, interrupt
    wire [3:0] ev = {rx_push && rxf_full, rx_err | (rx_push & |rx_entry[11:8]),
                     rx_push, tx_done};
    wire       ist_clr = wr && pwr && addr == `UART_ICLR_ADDR;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r   <= `UART_CTRL_RST;
            baud_r   <= `UART_BAUD_RST;
            fmt_r    <= `UART_FMT_RST;
            ien_r    <= `UART_IEN_RST;
            ist_r    <= 4'h0;
            peripheral_power_enable_r <= 1'b0;
            peripheral_power_status   <= 1'b0;
            rx_s1_r  <= 1'b1;
            rx_s2_r  <= 1'b1;
            cts_s1_r <= 1'b1;
            cts_s2_r <= 1'b1;
            rts_n    <= 1'b1;
            irq      <= 1'b0;
            rdata    <= 32'h0000_0000;
        end else begin
            rx_s1_r  <= rxd;
            rx_s2_r  <= rx_s1_r;
            cts_s1_r <= cts_n;
            cts_s2_r <= cts_s1_r;
            peripheral_power_status <= peripheral_power_enable_r;
            rts_n <= !(ctrl_r[`CTRL_FLOW] && rxf_cnt < 6'd28);
            ist_r <= (ist_clr ? ist_r & ~wdata[3:0] : ist_r) | ev;
            irq   <= |(ist_r & ien_r);
            if (wr && addr == `UART_POWER_ADDR)
                peripheral_power_enable_r <= wdata[0];
            if (wr && pwr) begin
                case (addr)
                    `UART_CTRL_ADDR: ctrl_r <= wdata[7:0];
                    `UART_BAUD_ADDR: baud_r <= wdata[15:0];
                    `UART_FMT_ADDR:  fmt_r  <= wdata[4:0];
                    `UART_IEN_ADDR:  ien_r  <= wdata[3:0];
                    default: ;
                endcase
            end
            rdata <= 32'h0000_0000;
            // Unpowered block answers only on the power register
            if (rd && (pwr || addr == `UART_POWER_ADDR)) begin
                case (addr)
                    `UART_DATA_ADDR:   rdata <= pwr ? {20'h0_0000, rxf_q} : 32'h0000_0000;
                    `UART_STATUS_ADDR: rdata <= {16'h0000, 2'b00, rxf_cnt, 2'b00,
                                         txf_cnt[5:0] == 6'd0 ? 1'b1 : 1'b0,
                                         rx_busy, txf_full, txf_empty,
                                         rxf_full, rxf_empty};
                    `UART_CTRL_ADDR:   rdata <= {24'h00_0000, ctrl_r};
                    `UART_BAUD_ADDR:   rdata <= {16'h0000, baud_r};
                    `UART_FMT_ADDR:    rdata <= {27'h000_0000, fmt_r};
                    `UART_IEN_ADDR:    rdata <= {28'h000_0000, ien_r};
                    `UART_ISTAT_ADDR:  rdata <= {28'h000_0000, ist_r};
                    `UART_POWER_ADDR:  rdata <= {30'h0000_0000,
                                         peripheral_power_status, pwr};
                    default:           rdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // uart_with_fifos

// ==== hdl/uart_regs.vh ====
`ifndef UART_REGS_VH
`define UART_REGS_VH

// Register offsets (byte addresses)
`define UART_DATA_ADDR      8'h00
`define UART_STATUS_ADDR    8'h04
`define UART_CTRL_ADDR      8'h08
`define UART_BAUD_ADDR      8'h0C
`define UART_FMT_ADDR       8'h10
`define UART_IEN_ADDR       8'h14
`define UART_ISTAT_ADDR     8'h18
`define UART_ICLR_ADDR      8'h1C
`define UART_POWER_ADDR     8'h20

// Reset values
`define UART_CTRL_RST       8'h00
`define UART_BAUD_RST       16'h0044
`define UART_FMT_RST        5'h03
`define UART_IEN_RST        4'h0

// Control bit positions
`define CTRL_TXEN           0
`define CTRL_RXEN           1
`define CTRL_FLOW           2
`define CTRL_LOOP           3
`define CTRL_HALF           4

// Format fields: [1:0] data bits-5, [2] parity on, [3] odd parity, [4] two stops
`define FMT_LEN_LO          0
`define FMT_PAR_EN          2
`define FMT_PAR_ODD         3
`define FMT_STOP2           4

// Interrupt bits
`define IRQ_TX              0
`define IRQ_RX              1
`define IRQ_ERR             2
`define IRQ_OVR             3

// Receive entry error bits above the data byte
`define RXE_FRAME           8
`define RXE_PARITY          9
`define RXE_BREAK           10
`define RXE_OVERRUN         11

// Oversampling ratio per bit
`define UART_OVS            16

`endif

// ==== hdl/uart_fifo.v ====
`timescale 1ns/10ps
module uart_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst,
    // Write side
    input  wire             wr_en,
    input  wire [WIDTH-1:0] wr_data,
    // Read side
    input  wire             rd_en,
    output wire [WIDTH-1:0] rd_data,
    // State
    output wire             empty,
    output wire             full,
    output wire [AW:0]      count
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0]    wp_r;
    reg [AW-1:0]    rp_r;
    reg [AW:0]      cnt_r;
    wire            do_wr = wr_en && !full;
    wire            do_rd = rd_en && !empty;
    integer         i;

    assign rd_data = mem_r[rp_r];
    assign empty   = (cnt_r == {(AW+1){1'b0}});
    assign full    = (cnt_r == DEPTH[AW:0]);
    assign count   = cnt_r;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_r[i] <= {WIDTH{1'b0}};
            end
        end else begin
            if (do_wr) begin
                mem_r[wp_r] <= wr_data;
                wp_r        <= wp_r + 1'b1;
            end
            if (do_rd) begin
                rp_r <= rp_r + 1'b1;
            end
            if (do_wr && !do_rd) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (do_rd && !do_wr) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // uart_fifo

// ==== testbench/uart_with_fifos_checker.sv ====
`timescale 1ns/10ps
module uart_with_fifos_checker #(
    parameter DEPTH = 32
) (
    // Clock and reset
    input wire        clk,
    input wire        rst,
    // Register port
    input wire [7:0]  addr,
    input wire [31:0] wdata,
    input wire        wr,
    input wire        rd,
    input wire [31:0] rdata,
    // Serial pins
    input wire        rxd,
    input wire        cts_n,
    input wire        txd,
    input wire        rts_n,
    // Interrupt and power
    input wire        irq,
    input wire        peripheral_power_status
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    reg flow_r;
    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of the flow control enable
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            flow_r <= 1'b0;
        end else if (wr && addr == 8'h08 && peripheral_power_status) begin
            flow_r <= wdata[2];
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_rst_idle;
        $fell(rst) |-> txd && rts_n && !irq && rdata == 32'h0000_0000;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle");
    property p_rdata_idle;
        !rd |=> rdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
    property p_pwr_off_read;
        !$past(wr) && rd && addr != 8'h20 && !peripheral_power_status
            |=> rdata == 32'h0000_0000;
    endproperty
    a_pwr_off_read: assert property (p_pwr_off_read) else $error("unpowered read");
    property p_pwr_status;
        wr && addr == 8'h20 |-> ##2 peripheral_power_status == $past(wdata[0], 2);
    endproperty
    a_pwr_status: assert property (p_pwr_status) else $error("power status lag");
    property p_start_bit;
        $fell(txd) |-> !txd [*8];
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("low bit too short");
    property p_irq_mask;
        wr && addr == 8'h14 && wdata[3:0] == 4'h0 && peripheral_power_status
            |-> ##2 !irq [*4];
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked irq high");
    property p_rts_off;
        wr && addr == 8'h08 && !wdata[2] && peripheral_power_status |-> ##2 rts_n;
    endproperty
    a_rts_off: assert property (p_rts_off) else $error("rts low, flow off");
    property p_cts_hold;
        flow_r && cts_n && $past(cts_n) && $past(cts_n, 2) && $past(cts_n, 3) && txd
            |=> txd;
    endproperty
    a_cts_hold: assert property (p_cts_hold) else $error("frame began, cts high");
endmodule // uart_with_fifos_checker

bind uart_with_fifos uart_with_fifos_checker #(.DEPTH(DEPTH)) chk_i (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rxd(rxd), .cts_n(cts_n), .txd(txd), .rts_n(rts_n),
    .irq(irq), .peripheral_power_status(peripheral_power_status));

// ==== testbench/serial_device.sv ====
`timescale 1ns/10ps
module serial_device #(
    parameter BIT = 16
) (
    // Clock
    input wire  clk,
    // Serial line
    input wire  txd,
    input wire  rts_n,
    output reg  rxd,
    output reg  cts_n
);
    logic [7:0] got[$];
    logic [7:0] b;
    logic       flow = 1'b0;
    initial begin
        rxd = 1'b1;
        cts_n = 1'b0;
    end
    // Sample mid-bit on the falling edge, away from the block's launch edge
    always begin
        @(negedge clk);
        if (txd === 1'b0) begin
            repeat (BIT / 2) @(negedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(negedge clk);
                b[i] = txd;
            end
            repeat (BIT) @(negedge clk);
            if (txd === 1'b1) got.push_back(b);
        end
    end
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        while (flow && rts_n !== 1'b0) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            rxd <= f[i];
            repeat (BIT - 1) @(posedge clk);
        end
    endtask
endmodule // serial_device

// ==== testbench/uart_with_fifos_tb.sv ====
`timescale 1ns/10ps
module uart_with_fifos_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    wire  [31:0] rdata;
    wire         rxd;
    wire         cts_n;
    wire         txd;
    wire         rts_n;
    wire         irq;
    wire         pwr_st;
    int          failures = 0;
    int          checks = 0;
    int          cyc = 0;
    int          seed = 32'h28d8;
    int          n;
    logic [31:0] v;
    logic [7:0]  b;
    logic [7:0]  exp_tx[$];
    logic [7:0]  exp_rx[$];
    logic [7:0]  fmt_tab[4] = '{8'h00, 8'h05, 8'h0E, 8'h13};
    uart_with_fifos #(.DEPTH(32)) dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .cts_n(cts_n), .txd(txd),
        .rts_n(rts_n), .irq(irq), .peripheral_power_status(pwr_st));
    serial_device #(.BIT(16)) dev (.clk(clk), .txd(txd), .rts_n(rts_n), .rxd(rxd),
        .cts_n(cts_n));
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failures++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (failures == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic wait_rx();
        for (int i = 0; i < 100; i++) begin
            rd_reg(8'h04, v);
            if (v[0] === 1'b0) break;
        end
    endtask
    task automatic wait_got(input int k);
        for (int i = 0; i < 3000 && dev.got.size() < k; i++) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd_reg(8'h0C, v);
        chk(v, 32'h0000_0000);
        wr_reg(8'h20, 32'h0000_0001);
        rd_reg(8'h20, v);
        chk(v, 32'h0000_0003);
        rd_reg(8'h0C, v);
        chk(v, 32'h0000_0044);
        rd_reg(8'h10, v);
        chk(v, 32'h0000_0003);
        rd_reg(8'h3C, v);
        chk(v, 32'h0000_0000);
        rd_reg(8'h04, v);
        chk(v, 32'h0000_0025);
        // Bit time of 16 clocks, receive interrupt, both directions at once
        wr_reg(8'h0C, 32'h0000_0000);
        wr_reg(8'h14, 32'h0000_0002);
        wr_reg(8'h08, 32'h0000_0003);
        fork
            for (int i = 0; i < 4; i++) begin
                b = 8'($random(seed));
                exp_tx.push_back(b);
                wr_reg(8'h00, {24'h0, b});
            end
            for (int i = 0; i < 2; i++) begin
                exp_rx.push_back(8'($random(seed)));
                dev.send(exp_rx[i]);
            end
        join
        wait_got(4);
        for (int i = 0; i < 4; i++) chk({24'h0, dev.got[i]}, {24'h0, exp_tx[i]});
        chk({31'h0, irq}, 32'h0000_0001);
        for (int i = 0; i < 2; i++) begin
            rd_reg(8'h00, v);
            chk(v, {24'h0, exp_rx[i]});
        end
        wr_reg(8'h1C, 32'h0000_000F);
        repeat (2) @(negedge clk);
        chk({31'h0, irq}, 32'h0000_0000);
        wr_reg(8'h14, 32'h0000_0000);
        // Loopback through every data length, parity off, even, odd, two stops
        wr_reg(8'h08, 32'h0000_000B);
        foreach (fmt_tab[k]) begin
            wr_reg(8'h10, {24'h0, fmt_tab[k]});
            b = 8'($random(seed));
            wr_reg(8'h00, {24'h0, b});
            wait_rx();
            rd_reg(8'h00, v);
            chk(v, {24'h0, b & 8'((9'h1 << (fmt_tab[k][1:0] + 5)) - 1)});
        end
        // Flow control: held while cts_n is high, released when it drops
        wr_reg(8'h10, 32'h0000_0003);
        dev.cts_n <= 1'b1;
        wr_reg(8'h08, 32'h0000_0007);
        // Let the far side finish any frame it locked onto during loopback
        repeat (200) @(negedge clk);
        chk({31'h0, rts_n}, 32'h0000_0000);
        n = dev.got.size();
        b = 8'($random(seed));
        wr_reg(8'h00, {24'h0, b});
        repeat (300) @(posedge clk);
        chk(32'(dev.got.size()), 32'(n));
        dev.cts_n <= 1'b0;
        wait_got(n + 1);
        chk({24'h0, dev.got[n]}, {24'h0, b});
        dev.flow = 1'b1;
        b = 8'($random(seed));
        dev.send(b);
        wait_rx();
        rd_reg(8'h00, v);
        chk(v, {24'h0, b});
        // Half duplex: a byte queued while a frame arrives waits for its end
        wr_reg(8'h08, 32'h0000_0017);
        n = dev.got.size();
        b = 8'($random(seed));
        exp_rx.push_back(8'($random(seed)));
        fork
            dev.send(exp_rx[2]);
            begin
                repeat (40) @(posedge clk);
                wr_reg(8'h00, {24'h0, b});
            end
        join
        repeat (80) @(posedge clk);
        chk(32'(dev.got.size()), 32'(n));
        wait_got(n + 1);
        chk({24'h0, dev.got[n]}, {24'h0, b});
        rd_reg(8'h00, v);
        chk(v, {24'h0, exp_rx[2]});
        tally_and_finish();
    end
endmodule // uart_with_fifos_tb
